// ==== hw/clock_gear_map.vh ====
`ifndef CLOCK_GEAR_MAP_VH
`define CLOCK_GEAR_MAP_VH
// Register offsets (byte addresses)
`define OFS_SYSTEM_CLOCK_CONFIG  6'h00
`define OFS_OSCILLATOR_CONTROL   6'h04
`define OFS_STANDBY_CONTROL      6'h08
`define OFS_PLL_SELECTION        6'h0C
`define OFS_RESERVED             6'h10
`define OFS_POWERON_STATUS       6'h14
// Decoded address width
`define ADDR_W                   6
// System clock config fields
`define SCC_SRC_BIT              12
`define SCC_PRE_HI               10
`define SCC_PRE_LO               8
`define SCC_GEAR_HI              2
`define SCC_GEAR_LO              0
`define SCC_FIX_HI               17
`define SCC_FIX_LO               16
`define SCC_FIX_RST              2'b01
// Oscillator control fields
`define OSC_WU_HI                31
`define OSC_WU_LO                20
`define OSC_WU_RST               12'h800
`define OSC_WUSRC_BIT            19
`define OSC_PINEN_BIT            18
`define OSC_HIGH_SPEED_OSC_SELECT_BIT           17
`define OSC_INTEN_BIT            16
`define OSC_EXTEN_BIT            8
`define OSC_LEGACY_BIT           3
`define OSC_PLL_BIT              2
`define OSC_WUFLAG_BIT           1
`define OSC_WUSTART_BIT          0
// Standby control reset value and writable mask (bits 16, 8 and 2:0 held)
`define STBY_RST                 32'h0000_0103
`define STBY_MASK                32'h0001_0107
// PLL selection reset value and writable mask
`define PLLSEL_RST               32'h0000_0000
`define PLLSEL_MASK              32'h0000_0001
// Reset vector word address
`define RESET_VECTOR_ADDR        32'h0000_0004
// Power-on reset stretch and pin filter timing
`define RST_MIN_NS               1200
`define CLK_PERIOD_NS            4
`define RST_MIN_CYCLES           ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_HOLD_CYCLES          16
// Warm-up timer prescale: count units of this many clocks
`define WU_TICK_CYCLES           16
// AXI response codes
`define RESP_OKAY                2'b00
`define RESP_SLVERR              2'b10
`endif

// ==== hw/clock_divider.v ====
`timescale 1ns/100ps
// Free-running divider; emits a one-cycle enable per 2**sel clocks, per 32 clocks for sel above 5
module clock_divider (
	input  wire       aclk,
	input  wire       rst_n,
	input  wire [2:0] sel,
	output reg        tick
);
	reg [4:0] cnt_q;
	wire [4:0] lim;

	// Limit is 2**sel - 1, held at 31 for sel above 5; sel 0 ticks every cycle
	assign lim = (sel > 3'd5) ? 5'h1F : (5'h1F >> (3'd5 - sel));

	// Count and strobe
	always @(posedge aclk) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
			tick  <= 1'b0;
		end else if (cnt_q >= lim) begin
			cnt_q <= 5'h00;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 5'h01;
			tick  <= 1'b0;
		end
	end
endmodule // clock_divider

// ==== hw/reset_and_clock_gear_control.v ====
`timescale 1ns/100ps
`include "clock_gear_map.vh"
// Functional notes
// - Power-on reset independent of reset pin
// - State undefined until pin reset seen
// - Reset release loads documented register values
// - PLL stopped after reset; software starts it
// - Core fetches start address from 0x0000_0004
// - Four writable registers plus read-only status at 0x14; 0x10 reserved
// - Bit 12 selects geared or undivided clock
// - Prescaler divides by 1 to 32
// - Gear: 000 undivided, 100-111 divide 2-16
// - Warm-up count field, reset 0x800
// - Internal osc resets on, external off
// - PLL run bit 2, resets stopped
// - Warm-up start write-one; active flag reads
module reset_and_clock_gear_control (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        reset_pin_n,
	input  wire        power_good,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         system_reset_n,
	output reg  [31:0] reset_vector_addr,
	output reg         gear_tick,
	output reg         periph_tick,
	output reg         prescale_tick,
	output reg         pll_run,
	output reg         internal_osc_enable,
	output reg         external_osc_enable,
	output reg         external_osc_pin_enable,
	output reg         high_speed_osc_select,
	output reg         warmup_active_flag
);
	localparam RST_CYC = `RST_MIN_CYCLES;

	// Byte-lane merge shared by all writable registers
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// Gear code to divide exponent; reserved codes fall back to undivided
	function [2:0] gear_exp;
		input [2:0] code;
		begin
			gear_exp = code[2] ? {1'b0, code[1:0]} + 3'd1 : 3'd0;
		end
	endfunction

	// Reset pin synchroniser: first stage feeds only the second
	reg pin_s1_q;
	reg pin_s2_q;
	reg pg_s1_q;
	reg pg_s2_q;
	always @(posedge aclk) begin
		pin_s1_q <= reset_pin_n;
		pin_s2_q <= pin_s1_q;
		pg_s1_q  <= power_good;
		pg_s2_q  <= pg_s1_q;
	end

	// Pin low time filter; short glitches never reset the block
	reg [9:0] low_cnt_q;
	reg       pin_rst_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			low_cnt_q <= 10'h000;
			pin_rst_q <= 1'b0;
		end else if (pin_s2_q || !pg_s2_q) begin
			low_cnt_q <= 10'h000;
			pin_rst_q <= 1'b0;
		end else if (low_cnt_q >= RST_CYC[9:0] - 10'h001) begin
			pin_rst_q <= 1'b1;
		end else begin
			low_cnt_q <= low_cnt_q + 10'h001;
		end
	end

	// Power-on stretch; aresetn stands for the supply-on event
	reg [4:0] por_cnt_q;
	reg       por_done_q;
	reg       pin_seen_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			por_cnt_q  <= 5'h00;
			por_done_q <= 1'b0;
			pin_seen_q <= 1'b0;
		end else begin
			if (!por_done_q) begin
				por_cnt_q  <= por_cnt_q + 5'h01;
				por_done_q <= (por_cnt_q == `POR_HOLD_CYCLES - 1);
			end
			if (pin_rst_q)
				pin_seen_q <= 1'b1;
		end
	end

	// Internal reset: held by power-on, pin, or until one pin reset seen
	wire int_rst;
	assign int_rst = !aresetn || !por_done_q || pin_rst_q || !pin_seen_q;

	// Registers
	reg [31:0] scc_q;
	reg [11:0] wu_count_q;
	reg        wu_src_q;
	reg        wu_legacy_q;
	reg [31:0] stby_q;
	reg [31:0] pllsel_q;
	reg [11:0] wu_timer_q;
	reg [3:0]  wu_pre_q;

	// AXI write channel capture, either order
	reg        aw_hold_q;
	reg        w_hold_q;
	reg [5:0]  waddr_q;
	reg [31:0] wdata_q;
	reg [3:0]  wstrb_q;
	wire       do_write;
	wire       wr_ok;
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wr_ok = (waddr_q < `OFS_RESERVED);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			waddr_q       <= 6'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				waddr_q   <= {s_axi_awaddr[5:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register file; internal reset restores documented values
	wire [31:0] scc_new;
	wire [31:0] osc_old;
	wire [31:0] osc_new;
	wire        wu_kick;
	assign scc_new = merge(scc_q, wdata_q, wstrb_q);
	assign osc_old = {wu_count_q, wu_src_q, external_osc_pin_enable,
		high_speed_osc_select, internal_osc_enable, 7'h00, external_osc_enable,
		4'h0, wu_legacy_q, pll_run, 2'b00};
	assign osc_new = merge(osc_old, wdata_q, wstrb_q);
	assign wu_kick = do_write && (waddr_q == `OFS_OSCILLATOR_CONTROL)
		&& wstrb_q[0] && wdata_q[`OSC_WUSTART_BIT];

	always @(posedge aclk) begin
		if (int_rst) begin
			scc_q                   <= {14'h0000, `SCC_FIX_RST, 16'h0000};
			wu_count_q              <= `OSC_WU_RST;
			wu_src_q                <= 1'b0;
			external_osc_pin_enable <= 1'b0;
			high_speed_osc_select   <= 1'b0;
			internal_osc_enable     <= 1'b1;
			external_osc_enable     <= 1'b0;
			wu_legacy_q             <= 1'b0;
			pll_run                 <= 1'b0;
			stby_q                  <= `STBY_RST;
			pllsel_q                <= `PLLSEL_RST;
		end else if (do_write) begin
			case (waddr_q)
				`OFS_SYSTEM_CLOCK_CONFIG: begin
					// Only source, prescaler, gear and fixed field stored
					scc_q <= scc_new & 32'h0003_1707;
				end
				`OFS_OSCILLATOR_CONTROL: begin
					wu_count_q              <= osc_new[`OSC_WU_HI:`OSC_WU_LO];
					wu_src_q                <= osc_new[`OSC_WUSRC_BIT];
					external_osc_pin_enable <= osc_new[`OSC_PINEN_BIT];
					high_speed_osc_select   <= osc_new[`OSC_HIGH_SPEED_OSC_SELECT_BIT];
					internal_osc_enable     <= osc_new[`OSC_INTEN_BIT];
					external_osc_enable     <= osc_new[`OSC_EXTEN_BIT];
					wu_legacy_q             <= osc_new[`OSC_LEGACY_BIT];
					pll_run                 <= osc_new[`OSC_PLL_BIT];
				end
				`OFS_STANDBY_CONTROL: begin
					stby_q <= merge(stby_q, wdata_q, wstrb_q) & `STBY_MASK;
				end
				`OFS_PLL_SELECTION: begin
					pllsel_q <= merge(pllsel_q, wdata_q, wstrb_q) & `PLLSEL_MASK;
				end
				default: begin
					scc_q <= scc_q;
				end
			endcase
		end
	end

	// Warm-up timer: counts wu_count ticks of WU_TICK_CYCLES clocks
	always @(posedge aclk) begin
		if (int_rst) begin
			wu_timer_q         <= 12'h000;
			wu_pre_q           <= 4'h0;
			warmup_active_flag <= 1'b0;
		end else if (wu_kick) begin
			// Count written with the start bit applies at once, not the old count
			wu_timer_q         <= osc_new[`OSC_WU_HI:`OSC_WU_LO];
			wu_pre_q           <= 4'h0;
			warmup_active_flag <= (osc_new[`OSC_WU_HI:`OSC_WU_LO] != 12'h000);
		end else if (warmup_active_flag) begin
			wu_pre_q <= wu_pre_q + 4'h1;
			if (wu_pre_q == `WU_TICK_CYCLES - 1) begin
				wu_timer_q <= wu_timer_q - 12'h001;
				if (wu_timer_q == 12'h001)
					warmup_active_flag <= 1'b0;
			end
		end
	end

	// Read channel; reserved and unmapped addresses answer SLVERR
	reg [31:0] rd_val;
	reg        rd_ok;
	always @* begin
		rd_ok  = 1'b1;
		rd_val = 32'h0000_0000;
		case ({s_axi_araddr[5:2], 2'b00})
			`OFS_SYSTEM_CLOCK_CONFIG: rd_val = scc_q;
			`OFS_OSCILLATOR_CONTROL:  rd_val = {osc_old[31:2], warmup_active_flag, 1'b0};
			`OFS_STANDBY_CONTROL:     rd_val = stby_q;
			`OFS_PLL_SELECTION:       rd_val = pllsel_q;
			`OFS_POWERON_STATUS:      rd_val = {30'h0000_0000, pin_seen_q, por_done_q};
			default:                  rd_ok = 1'b0;
		endcase
		if (s_axi_araddr[31:6] != 26'h000_0000)
			rd_ok = 1'b0;
		if (!rd_ok)
			rd_val = 32'h0000_0000;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Gear and prescaler dividers
	wire g_tick;
	wire p_tick;
	wire per_src;
	assign per_src = scc_q[`SCC_SRC_BIT] ? 1'b1 : g_tick;

	clock_divider gear_div (
		.aclk (aclk),
		.rst_n(!int_rst),
		.sel  (gear_exp(scc_q[`SCC_GEAR_HI:`SCC_GEAR_LO])),
		.tick (g_tick)
	);

	// Prescaler counts peripheral-clock enables; reserved codes hold off
	reg [4:0] pre_cnt_q;
	wire [2:0] pre_sel;
	wire [4:0] pre_lim;
	assign pre_sel = scc_q[`SCC_PRE_HI:`SCC_PRE_LO];
	assign pre_lim = 5'h1F >> (3'd5 - ((pre_sel > 3'd5) ? 3'd5 : pre_sel));
	assign p_tick  = per_src && (pre_cnt_q >= pre_lim) && (pre_sel <= 3'd5);
	always @(posedge aclk) begin
		if (int_rst)
			pre_cnt_q <= 5'h00;
		else if (per_src)
			pre_cnt_q <= (pre_cnt_q >= pre_lim) ? 5'h00 : pre_cnt_q + 5'h01;
	end

	// Registered clock-enable outputs and reset status
	always @(posedge aclk) begin
		if (!aresetn) begin
			gear_tick         <= 1'b0;
			periph_tick       <= 1'b0;
			prescale_tick     <= 1'b0;
			system_reset_n    <= 1'b0;
			reset_vector_addr <= `RESET_VECTOR_ADDR;
		end else begin
			gear_tick         <= g_tick;
			periph_tick       <= per_src;
			prescale_tick     <= p_tick;
			system_reset_n    <= !int_rst;
			reset_vector_addr <= `RESET_VECTOR_ADDR;
		end
	end
endmodule // reset_and_clock_gear_control

// ==== tb/clock_gear_asserts.sv ====
`timescale 1ns/100ps
`include "clock_gear_map.vh"
// Bus handshake and reset-time output checks
module clock_gear_asserts (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        system_reset_n,
	input logic [31:0] reset_vector_addr,
	input logic        pll_run,
	input logic        internal_osc_enable,
	input logic        external_osc_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Handshake and reset-hold steps the properties build on
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence held_in_reset;
		!system_reset_n [*3];
	endsequence
	a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read response late");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_no_read_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
	a_vector_fixed: assert property (system_reset_n |-> reset_vector_addr == `RESET_VECTOR_ADDR)
		else $error("start vector address wrong");
	// Outputs lag the register reset, hence three cycles
	a_osc_reset_state: assert property (held_in_reset |-> !pll_run && internal_osc_enable && !external_osc_enable)
		else $error("oscillator controls not at reset state");
	a_por_quiet: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> !system_reset_n && !s_axi_bvalid && !s_axi_rvalid)
		else $error("power-on reset not taken");
endmodule // clock_gear_asserts

bind reset_and_clock_gear_control clock_gear_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .system_reset_n,
	.reset_vector_addr, .pll_run, .internal_osc_enable, .external_osc_enable);

// ==== tb/reset_and_clock_gear_control_tb_top.sv ====
`timescale 1ns/100ps
`include "clock_gear_map.vh"
module reset_and_clock_gear_control_tb_top;
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  strb;
		logic [31:0] wdata;
		logic [31:0] rexp;
		logic [1:0]  resp;
	} row_t;
	logic        aclk = 0, aresetn = 0, reset_pin_n = 1, power_good = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d;
	logic [3:0]  s_axi_wstrb = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [1:0]  r;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata, reset_vector_addr;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         system_reset_n, gear_tick, periph_tick, prescale_tick, pll_run;
	wire         internal_osc_enable, external_osc_enable, external_osc_pin_enable;
	wire         high_speed_osc_select, warmup_active_flag;
	int          errors = 0, checks_done = 0, cycles = 0, n, gc, pc, sc;
	logic [31:0] rst_val [4] = '{32'h0001_0000, 32'h8001_0000, 32'h0000_0103, 32'h0000_0000};
	// Ordinary register cases: address, lanes, write data, read back, response
	row_t        rows [7] = '{
		'{32'h0000_0000, 4'hF, 32'hFFFD_FFFF, 32'h0001_1707, `RESP_OKAY},
		'{32'h0000_0000, 4'hF, 32'h0001_1504, 32'h0001_1504, `RESP_OKAY},
		'{32'h0000_0000, 4'h2, 32'h0000_0700, 32'h0001_0704, `RESP_OKAY},
		'{32'h0000_0008, 4'hF, 32'hFFFF_FFFF, 32'h0001_0107, `RESP_OKAY},
		'{32'h0000_000C, 4'hF, 32'hFFFF_FFFF, 32'h0000_0001, `RESP_OKAY},
		'{32'h0000_0004, 4'hF, 32'h000E_010C, 32'h000E_010C, `RESP_OKAY},
		'{32'h0000_0010, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000, `RESP_SLVERR}};

	reset_and_clock_gear_control DUT (.aclk, .aresetn, .reset_pin_n, .power_good,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .system_reset_n, .reset_vector_addr, .gear_tick,
		.periph_tick, .prescale_tick, .pll_run, .internal_osc_enable, .external_osc_enable,
		.external_osc_pin_enable, .high_speed_osc_select, .warmup_active_flag);

	// 250 MHz clock
	always #2 aclk = ~aclk;

	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Write waits for its answer however long it takes; the bench timeout bounds it
	task automatic wr(input logic [31:0] a, dat, input logic [3:0] s);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask

	// Settle past the longest divider period, then count ticks in 64 cycles
	task automatic cnt;
		repeat (40) @(posedge aclk);
		gc = 0;
		pc = 0;
		sc = 0;
		repeat (64) begin
			@(posedge aclk);
			gc += (gear_tick === 1'b1);
			pc += (periph_tick === 1'b1);
			sc += (prescale_tick === 1'b1);
		end
	endtask

	task automatic pin(input int k);
		reset_pin_n <= 0;
		repeat (k) @(posedge aclk);
		reset_pin_n <= 1;
		repeat (20) @(posedge aclk);
		n = 0;
		while (system_reset_n !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic conclude;
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, well above the few thousand cycles the run needs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			conclude;
		end
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		repeat (40) @(posedge aclk);
		chk(system_reset_n, 0);
		pin(320);
		chk(system_reset_n, 1);
		chk(reset_vector_addr, `RESET_VECTOR_ADDR);
		chk({pll_run, internal_osc_enable, external_osc_enable}, 3'h2);
		for (int i = 0; i < 4; i++) begin
			rd(i * 4);
			chk(d, rst_val[i]);
		end
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata, rows[i].strb);
			chk(r, rows[i].resp);
			rd(rows[i].addr);
			chk(r, rows[i].resp);
			if (rows[i].resp == `RESP_OKAY) chk(d, rows[i].rexp);
		end
		chk({pll_run, internal_osc_enable, external_osc_enable, external_osc_pin_enable,
			high_speed_osc_select}, 5'h17);
		// Reserved gear codes run undivided in this design
		for (int g = 0; g < 8; g++) begin
			wr(32'h0000_0000, 32'h0001_0000 | g, 4'hF);
			cnt;
			chk(gc, g < 4 ? 64 : 64 >> (g - 3));
			chk(pc, gc);
		end
		for (int p = 0; p < 8; p++) begin
			wr(32'h0000_0000, 32'h0001_1000 | (p << 8), 4'hF);
			cnt;
			chk(pc, 64);
			chk(sc, p < 6 ? 64 >> p : 0);
		end
		// Warm-up count of 3 units with the PLL kept running
		wr(32'h0000_0004, 32'h0030_0005, 4'hF);
		chk(warmup_active_flag, 1);
		rd(32'h0000_0004);
		chk(d, 32'h0030_0006);
		repeat (60) @(posedge aclk);
		chk(warmup_active_flag, 0);
		// A short pin pulse and one with the supply out of range are both ignored
		pin(100);
		power_good <= 0;
		pin(320);
		power_good <= 1;
		chk(system_reset_n, 1);
		rd(32'h0000_0000);
		chk(d, 32'h0001_1700);
		pin(320);
		rd(32'h0000_0000);
		chk(d, 32'h0001_0000);
		chk(pll_run, 0);
		conclude;
	end
endmodule // reset_and_clock_gear_control_tb_top
